// File: core/dms_map.vh
`ifndef DMS_MAP_VH
`define DMS_MAP_VH
// register byte offsets
`define DMS_OFS_GLOBAL_EN 8'h00
`define DMS_OFS_HANDLER 8'h04
`define DMS_OFS_STATUS 8'h08
`define DMS_OFS_IRQ_STATUS 8'h0C
`define DMS_OFS_IRQ_MASK 8'h10
`define DMS_OFS_SADDR 8'h14
`define DMS_OFS_DADDR 8'h18
`define DMS_OFS_DSCR 8'h1C
`define DMS_OFS_CTRLA 8'h20
`define DMS_OFS_CTRLB 8'h24
`define DMS_OFS_CFG 8'h28
`define DMS_OFS_SOURCE_PIP_ENABLE 8'h2C
`define DMS_OFS_DEST_PIP_ENABLE 8'h30
`define DMS_OFS_SWREQ 8'h34
// global enable, handler and status fields
`define DMS_GLOBAL_EN_BIT 0
`define DMS_HANDLER_ENA_BIT 0
`define DMS_HANDLER_KEEP_BIT 8
`define DMS_STATUS_ENA_BIT 0
`define DMS_STATUS_STALL_BIT 8
// irq status and mask fields
`define DMS_IRQ_BTC_BIT 0
`define DMS_IRQ_CBTC_BIT 8
// control word a
`define DMS_CTRLA_SIZE_MSB 15
`define DMS_CTRLA_SIZE_LSB 0
`define DMS_CTRLA_SWIDTH_MSB 25
`define DMS_CTRLA_SWIDTH_LSB 24
`define DMS_CTRLA_DWIDTH_MSB 29
`define DMS_CTRLA_DWIDTH_LSB 28
`define DMS_CTRLA_DONE_BIT 31
// control word b
`define DMS_CTRLB_SLAYER_BIT 0
`define DMS_CTRLB_DLAYER_BIT 4
`define DMS_CTRLB_SOURCE_PIP_ENABLE_BIT 8
`define DMS_CTRLB_DEST_PIP_ENABLE_BIT 12
`define DMS_CTRLB_DLINK_BIT 16
`define DMS_CTRLB_FC_MSB 22
`define DMS_CTRLB_FC_LSB 21
`define DMS_CTRLB_SSTEP_MSB 25
`define DMS_CTRLB_SSTEP_LSB 24
`define DMS_CTRLB_DSTEP_MSB 29
`define DMS_CTRLB_DSTEP_LSB 28
`define DMS_CTRLB_AUTO_BIT 31
// channel configuration
`define DMS_CFG_SPER_MSB 3
`define DMS_CFG_SPER_LSB 0
`define DMS_CFG_DPER_MSB 7
`define DMS_CFG_DPER_LSB 4
`define DMS_CFG_SHW_BIT 9
`define DMS_CFG_DHW_BIT 13
// picture-in-picture registers
`define DMS_PIP_HOLE_MSB 15
`define DMS_PIP_HOLE_LSB 0
`define DMS_PIP_BOUND_MSB 25
`define DMS_PIP_BOUND_LSB 16
// descriptor layout
`define DMS_DSCR_LAYER_MSB 1
`define DMS_DSCR_LAYER_LSB 0
`define DMS_DESC_WORDS 3'h4
`define DMS_DESC_CTRLA_OFS 32'h00000008
// reset values
`define DMS_RST_WORD 32'h00000000
`endif

// File: core/dms_sync.v
`timescale 1ns/1ps
`default_nettype none
module dms_sync #(
  parameter WIDTH = 16
) (
  input wire i_ref_clk, // clock
  input wire i_rst_n, // async reset, active low
  input wire [WIDTH-1:0] i_async, // pin level
  output reg [WIDTH-1:0] o_sync // synchronised level
);
  reg [WIDTH-1:0] meta;

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta <= {WIDTH{1'b0}};
      o_sync <= {WIDTH{1'b0}};
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end
endmodule // dms_sync
`default_nettype wire

// File: core/dms_addr_step.v
`timescale 1ns/1ps
`default_nettype none
module dms_addr_step (
  input wire [31:0] i_addr, // current address
  input wire [1:0] i_width, // 0 byte, 1 half, 2 word
  input wire [1:0] i_step, // 0 incr, 1 decr, else fixed
  input wire i_pip_en, // picture-in-picture stepping on
  input wire i_pip_hit, // boundary reached on this item
  input wire [15:0] i_pip_hole, // extra bytes skipped at boundary
  output reg [31:0] o_next // address of next item
);
  reg [31:0] size;

  always @* begin
    size = (i_width == 2'h0) ? 32'h00000001 : (i_width == 2'h1) ? 32'h00000002 : 32'h00000004;
    if (i_step == 2'h0)
      o_next = i_addr + size;
    else if (i_step == 2'h1)
      o_next = i_addr - size;
    else
      o_next = i_addr;
    if (i_pip_en && i_pip_hit)
      o_next = o_next + {16'h0000, i_pip_hole};
  end
endmodule // dms_addr_step
`default_nettype wire

// File: core/dms_channel.v
// Notes on behaviour
// - handshake type bit per side: 1 hardware
// - hardware side uses configured peripheral number
// - fetch five words, drop fetched source address
// - first fetch from descriptor pointer register
// - write back control word a only
// - done bit set in written-back word
// - linked mode restores initial source address
// - terminating row: chained flag, channel disabled
// - otherwise fetch next descriptor, keep source
// - contiguous mode reloads source, keeps destination
// - unmasked auto mode stalls until resume write
// - masked auto mode continues without stall
// - start needs channel and global enable
// - reading irq status clears pending flags
// - acknowledge each hardware-handshake peripheral transaction on completion
// - honour flow control, widths, layers, stepping
// - pip enable uses pip register stepping
//
// The implementer's own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "dms_map.vh"
module dms_channel (
  input wire i_ref_clk, // 100 MHz clock
  input wire i_rst_n, // async reset, active low
  input wire i_wb_cyc, // wishbone cycle
  input wire i_wb_stb, // wishbone strobe
  input wire i_wb_we, // wishbone write
  input wire [31:0] i_wb_adr, // wishbone byte address
  input wire [3:0] i_wb_sel, // wishbone byte enables
  input wire [31:0] i_wb_dat, // wishbone write data
  output reg [31:0] o_wb_dat, // wishbone read data
  output reg o_wb_ack, // wishbone acknowledge
  output reg o_mem_req, // memory request, held until ack
  output reg o_mem_we, // memory write
  output reg [31:0] o_mem_addr, // memory address
  output reg [31:0] o_mem_wdata, // memory write data
  output reg [1:0] o_mem_layer, // bus layer select
  output reg [1:0] o_mem_size, // transfer width
  input wire i_mem_ack, // memory done, one cycle
  input wire [31:0] i_mem_rdata, // memory read data
  input wire [15:0] i_periph_req, // peripheral requests (pins)
  output reg [15:0] o_periph_ack, // peripheral ack pulses
  output reg o_irq // interrupt, active high
);
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_FETCH = 7'h02;
  localparam [6:0] ST_RD = 7'h04;
  localparam [6:0] ST_WR = 7'h08;
  localparam [6:0] ST_WB = 7'h10;
  localparam [6:0] ST_END = 7'h20;
  localparam [6:0] ST_STALL = 7'h40;

  reg [6:0] state;
  reg global_en;
  reg chan_en;
  reg stall;
  reg [31:0] irq_status;
  reg [31:0] irq_mask;
  reg [31:0] saddr;
  reg [31:0] daddr;
  reg [31:0] dscr;
  reg [31:0] ctrla;
  reg [31:0] ctrlb;
  reg [31:0] cfg;
  reg [31:0] source_pip_enable;
  reg [31:0] dest_pip_enable;
  reg [1:0] sw_req;
  reg [31:0] init_saddr;
  reg [31:0] fetch_ptr;
  reg [1:0] fetch_layer;
  reg [2:0] fetch_idx;
  reg [31:0] data_buf;
  reg [15:0] xfer_cnt;
  reg [9:0] source_pip_enable_cnt;
  reg [9:0] dest_pip_enable_cnt;
  reg [31:0] rd_val;
  wire [15:0] req_sync;
  wire [31:0] s_next;
  wire [31:0] d_next;

  wire wb_hit = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire wb_wr = wb_hit & i_wb_we;
  wire wb_rd = wb_hit & ~i_wb_we;
  wire [31:0] wmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
  wire [1:0] fc = ctrlb[`DMS_CTRLB_FC_MSB:`DMS_CTRLB_FC_LSB];
  wire src_is_per = fc[1];
  wire dst_is_per = fc[0];
  wire src_hw = cfg[`DMS_CFG_SHW_BIT];
  wire dst_hw = cfg[`DMS_CFG_DHW_BIT];
  wire [3:0] source_peripheral_num = cfg[`DMS_CFG_SPER_MSB:`DMS_CFG_SPER_LSB];
  wire [3:0] dest_peripheral_num = cfg[`DMS_CFG_DPER_MSB:`DMS_CFG_DPER_LSB];
  wire linked = ctrlb[`DMS_CTRLB_DLINK_BIT];
  // memory sides never wait on a handshake
  wire src_ok = ~src_is_per | (src_hw ? req_sync[source_peripheral_num] : sw_req[0]);
  wire dst_ok = ~dst_is_per | (dst_hw ? req_sync[dest_peripheral_num] : sw_req[1]);
  wire [15:0] buf_size = ctrla[`DMS_CTRLA_SIZE_MSB:`DMS_CTRLA_SIZE_LSB];
  // a zero size still moves one item rather than wrapping the counter
  wire last_item = (xfer_cnt + 16'h0001) >= buf_size;
  wire [9:0] source_pip_enable_bound = source_pip_enable[`DMS_PIP_BOUND_MSB:`DMS_PIP_BOUND_LSB];
  wire [9:0] dest_pip_enable_bound = dest_pip_enable[`DMS_PIP_BOUND_MSB:`DMS_PIP_BOUND_LSB];
  wire source_pip_enable_hit = (source_pip_enable_cnt == source_pip_enable_bound);
  wire dest_pip_enable_hit = (dest_pip_enable_cnt == dest_pip_enable_bound);
  // row 1: linked chain ends on a zero pointer, contiguous on auto cleared
  wire terminate = linked ? (dscr[31:2] == 30'h00000000) : ~ctrlb[`DMS_CTRLB_AUTO_BIT];

  dms_sync #(
    .WIDTH(16)
  ) u_req_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_async(i_periph_req),
    .o_sync(req_sync)
  );

  dms_addr_step u_src_step (
    .i_addr(saddr),
    .i_width(ctrla[`DMS_CTRLA_SWIDTH_MSB:`DMS_CTRLA_SWIDTH_LSB]),
    .i_step(ctrlb[`DMS_CTRLB_SSTEP_MSB:`DMS_CTRLB_SSTEP_LSB]),
    .i_pip_en(ctrlb[`DMS_CTRLB_SOURCE_PIP_ENABLE_BIT]),
    .i_pip_hit(source_pip_enable_hit),
    .i_pip_hole(source_pip_enable[`DMS_PIP_HOLE_MSB:`DMS_PIP_HOLE_LSB]),
    .o_next(s_next)
  );

  dms_addr_step u_dst_step (
    .i_addr(daddr),
    .i_width(ctrla[`DMS_CTRLA_DWIDTH_MSB:`DMS_CTRLA_DWIDTH_LSB]),
    .i_step(ctrlb[`DMS_CTRLB_DSTEP_MSB:`DMS_CTRLB_DSTEP_LSB]),
    .i_pip_en(ctrlb[`DMS_CTRLB_DEST_PIP_ENABLE_BIT]),
    .i_pip_hit(dest_pip_enable_hit),
    .i_pip_hole(dest_pip_enable[`DMS_PIP_HOLE_MSB:`DMS_PIP_HOLE_LSB]),
    .o_next(d_next)
  );

  always @* begin
    rd_val = `DMS_RST_WORD;
    case (i_wb_adr[7:0])
      `DMS_OFS_GLOBAL_EN: rd_val[`DMS_GLOBAL_EN_BIT] = global_en;
      `DMS_OFS_STATUS: begin
        rd_val[`DMS_STATUS_ENA_BIT] = chan_en;
        rd_val[`DMS_STATUS_STALL_BIT] = stall;
      end
      `DMS_OFS_IRQ_STATUS: rd_val = irq_status;
      `DMS_OFS_IRQ_MASK: rd_val = irq_mask;
      `DMS_OFS_SADDR: rd_val = saddr;
      `DMS_OFS_DADDR: rd_val = daddr;
      `DMS_OFS_DSCR: rd_val = dscr;
      `DMS_OFS_CTRLA: rd_val = ctrla;
      `DMS_OFS_CTRLB: rd_val = ctrlb;
      `DMS_OFS_CFG: rd_val = cfg;
      `DMS_OFS_SOURCE_PIP_ENABLE: rd_val = source_pip_enable;
      `DMS_OFS_DEST_PIP_ENABLE: rd_val = dest_pip_enable;
      `DMS_OFS_SWREQ: rd_val[1:0] = sw_req;
      default: rd_val = `DMS_RST_WORD;
    endcase
  end

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= `DMS_RST_WORD;
      o_irq <= 1'b0;
    end else begin
      o_wb_ack <= wb_hit;
      o_wb_dat <= wb_rd ? rd_val : `DMS_RST_WORD;
      o_irq <= |(irq_status & irq_mask);
    end
  end

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
      global_en <= 1'b0;
      chan_en <= 1'b0;
      stall <= 1'b0;
      irq_status <= `DMS_RST_WORD;
      irq_mask <= `DMS_RST_WORD;
      saddr <= `DMS_RST_WORD;
      daddr <= `DMS_RST_WORD;
      dscr <= `DMS_RST_WORD;
      ctrla <= `DMS_RST_WORD;
      ctrlb <= `DMS_RST_WORD;
      cfg <= `DMS_RST_WORD;
      source_pip_enable <= `DMS_RST_WORD;
      dest_pip_enable <= `DMS_RST_WORD;
      sw_req <= 2'h0;
      init_saddr <= `DMS_RST_WORD;
      fetch_ptr <= `DMS_RST_WORD;
      fetch_layer <= 2'h0;
      fetch_idx <= 3'h0;
      data_buf <= `DMS_RST_WORD;
      xfer_cnt <= 16'h0000;
      source_pip_enable_cnt <= 10'h000;
      dest_pip_enable_cnt <= 10'h000;
      o_mem_req <= 1'b0;
      o_mem_we <= 1'b0;
      o_mem_addr <= `DMS_RST_WORD;
      o_mem_wdata <= `DMS_RST_WORD;
      o_mem_layer <= 2'h0;
      o_mem_size <= 2'h0;
      o_periph_ack <= 16'h0000;
    end else begin
      o_periph_ack <= 16'h0000;
      // software side first so hardware updates below win the same cycle
      if (wb_rd && i_wb_adr[7:0] == `DMS_OFS_IRQ_STATUS)
        irq_status <= `DMS_RST_WORD;
      if (wb_wr) begin
        case (i_wb_adr[7:0])
          `DMS_OFS_GLOBAL_EN: if (i_wb_sel[0]) global_en <= i_wb_dat[`DMS_GLOBAL_EN_BIT];
          `DMS_OFS_HANDLER: begin
            if (i_wb_sel[0] && i_wb_dat[`DMS_HANDLER_ENA_BIT])
              chan_en <= 1'b1;
            if (i_wb_sel[1] && i_wb_dat[`DMS_HANDLER_KEEP_BIT])
              stall <= 1'b0;
          end
          `DMS_OFS_IRQ_MASK: irq_mask <= (irq_mask & ~wmask) | (i_wb_dat & wmask);
          `DMS_OFS_SADDR: saddr <= (saddr & ~wmask) | (i_wb_dat & wmask);
          `DMS_OFS_DADDR: daddr <= (daddr & ~wmask) | (i_wb_dat & wmask);
          `DMS_OFS_DSCR: dscr <= (dscr & ~wmask) | (i_wb_dat & wmask);
          `DMS_OFS_CTRLA: ctrla <= (ctrla & ~wmask) | (i_wb_dat & wmask);
          `DMS_OFS_CTRLB: ctrlb <= (ctrlb & ~wmask) | (i_wb_dat & wmask);
          `DMS_OFS_CFG: cfg <= (cfg & ~wmask) | (i_wb_dat & wmask);
          `DMS_OFS_SOURCE_PIP_ENABLE: source_pip_enable <= (source_pip_enable & ~wmask) | (i_wb_dat & wmask);
          `DMS_OFS_DEST_PIP_ENABLE: dest_pip_enable <= (dest_pip_enable & ~wmask) | (i_wb_dat & wmask);
          `DMS_OFS_SWREQ: if (i_wb_sel[0]) sw_req <= sw_req | i_wb_dat[1:0];
          default: ;
        endcase
      end
      case (state)
        ST_IDLE: begin
          if (chan_en && global_en) begin
            init_saddr <= saddr;
            xfer_cnt <= 16'h0000;
            source_pip_enable_cnt <= 10'h000;
            dest_pip_enable_cnt <= 10'h000;
            fetch_ptr <= {dscr[31:2], 2'b00};
            fetch_layer <= dscr[`DMS_DSCR_LAYER_MSB:`DMS_DSCR_LAYER_LSB];
            fetch_idx <= 3'h0;
            state <= linked ? ST_FETCH : ST_RD;
          end
        end
        ST_FETCH: begin
          if (!o_mem_req) begin
            o_mem_req <= 1'b1;
            o_mem_we <= 1'b0;
            o_mem_addr <= fetch_ptr + {27'h0000000, fetch_idx, 2'b00};
            o_mem_layer <= fetch_layer;
            o_mem_size <= 2'h2;
          end else if (i_mem_ack) begin
            o_mem_req <= 1'b0;
            // word 0 is the descriptor's source address and is dropped
            case (fetch_idx)
              3'h1: daddr <= i_mem_rdata;
              3'h2: ctrla <= i_mem_rdata;
              3'h3: ctrlb <= i_mem_rdata;
              3'h4: dscr <= i_mem_rdata;
              default: ;
            endcase
            fetch_idx <= fetch_idx + 3'h1;
            if (fetch_idx == `DMS_DESC_WORDS) begin
              xfer_cnt <= 16'h0000;
              state <= ST_RD;
            end
          end
        end
        ST_RD: begin
          if (!o_mem_req && src_ok) begin
            o_mem_req <= 1'b1;
            o_mem_we <= 1'b0;
            o_mem_addr <= saddr;
            o_mem_layer <= {1'b0, ctrlb[`DMS_CTRLB_SLAYER_BIT]};
            o_mem_size <= ctrla[`DMS_CTRLA_SWIDTH_MSB:`DMS_CTRLA_SWIDTH_LSB];
          end else if (o_mem_req && i_mem_ack) begin
            o_mem_req <= 1'b0;
            data_buf <= i_mem_rdata;
            state <= ST_WR;
          end
        end
        ST_WR: begin
          if (!o_mem_req && dst_ok) begin
            o_mem_req <= 1'b1;
            o_mem_we <= 1'b1;
            o_mem_addr <= daddr;
            o_mem_wdata <= data_buf;
            o_mem_layer <= {1'b0, ctrlb[`DMS_CTRLB_DLAYER_BIT]};
            o_mem_size <= ctrla[`DMS_CTRLA_DWIDTH_MSB:`DMS_CTRLA_DWIDTH_LSB];
          end else if (o_mem_req && i_mem_ack) begin
            o_mem_req <= 1'b0;
            o_periph_ack <= ((src_is_per && src_hw) ? (16'h0001 << source_peripheral_num) : 16'h0000) |
                            ((dst_is_per && dst_hw) ? (16'h0001 << dest_peripheral_num) : 16'h0000);
            sw_req <= 2'h0;
            saddr <= s_next;
            daddr <= d_next;
            source_pip_enable_cnt <= source_pip_enable_hit ? 10'h000 : source_pip_enable_cnt + 10'h001;
            dest_pip_enable_cnt <= dest_pip_enable_hit ? 10'h000 : dest_pip_enable_cnt + 10'h001;
            xfer_cnt <= xfer_cnt + 16'h0001;
            if (last_item) begin
              ctrla[`DMS_CTRLA_DONE_BIT] <= 1'b1;
              state <= linked ? ST_WB : ST_END;
            end else begin
              state <= ST_RD;
            end
          end
        end
        ST_WB: begin
          if (!o_mem_req) begin
            o_mem_req <= 1'b1;
            o_mem_we <= 1'b1;
            o_mem_addr <= fetch_ptr + `DMS_DESC_CTRLA_OFS;
            o_mem_wdata <= ctrla;
            o_mem_layer <= fetch_layer;
            o_mem_size <= 2'h2;
          end else if (i_mem_ack) begin
            o_mem_req <= 1'b0;
            state <= ST_END;
          end
        end
        ST_END: begin
          saddr <= init_saddr;
          irq_status[`DMS_IRQ_BTC_BIT] <= 1'b1;
          xfer_cnt <= 16'h0000;
          if (terminate) begin
            irq_status[`DMS_IRQ_CBTC_BIT] <= 1'b1;
            chan_en <= 1'b0;
            state <= ST_IDLE;
          end else if (linked) begin
            fetch_ptr <= {dscr[31:2], 2'b00};
            fetch_layer <= dscr[`DMS_DSCR_LAYER_MSB:`DMS_DSCR_LAYER_LSB];
            fetch_idx <= 3'h0;
            state <= ST_FETCH;
          end else if (irq_mask[`DMS_IRQ_BTC_BIT]) begin
            stall <= 1'b1;
            state <= ST_STALL;
          end else begin
            state <= ST_RD;
          end
        end
        ST_STALL: begin
          if (!stall)
            state <= ST_RD;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // dms_channel
`default_nettype wire

// File: tb/dms_chk_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module dms_chk (
  input wire logic i_ref_clk, // clock
  input wire logic i_rst_n, // reset, active low
  input wire logic i_wb_cyc, // bus cycle
  input wire logic i_wb_stb, // bus strobe
  input wire logic [31:0] o_wb_dat, // read data
  input wire logic o_wb_ack, // bus ack
  input wire logic o_mem_req, // memory request
  input wire logic o_mem_we, // memory write
  input wire logic [31:0] o_mem_addr, // memory address
  input wire logic i_mem_ack, // memory ack
  input wire logic [15:0] o_periph_ack // peripheral acks
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  chk_wb_answer_next: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("bus ack late");
  chk_wb_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("bus ack too long");
  chk_wb_ack_quiet: assert property (!(i_wb_cyc && i_wb_stb) |=> !o_wb_ack)
    else $error("bus ack without request");
  chk_wb_dat_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
    else $error("read data outside ack");
  chk_mem_req_hold: assert property (o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr) && $stable(o_mem_we))
    else $error("memory request changed before ack");
  chk_mem_req_drop: assert property (o_mem_req && i_mem_ack |=> !o_mem_req)
    else $error("memory request kept after ack");
  // an item needs a read and a write, so pulses are well apart
  chk_pack_gap: assert property (|o_periph_ack |=> (o_periph_ack == 16'h0) [*3])
    else $error("peripheral ack pulses too close");
  chk_pack_after_write: assert property ($rose(|o_periph_ack) |-> $past(o_mem_req && o_mem_we && i_mem_ack))
    else $error("peripheral ack not after write");
  cover property (o_mem_req && o_mem_we && i_mem_ack);
  cover property ($rose(|o_periph_ack));
  cover property (o_wb_ack && o_wb_dat != 32'h0);
endmodule // dms_chk
bind dms_channel dms_chk chk_i (.i_ref_clk, .i_rst_n, .i_wb_cyc, .i_wb_stb, .o_wb_dat, .o_wb_ack,
  .o_mem_req, .o_mem_we, .o_mem_addr, .i_mem_ack, .o_periph_ack);
`default_nettype wire

// File: tb/dms_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module dms_mem_model (
  input wire logic i_ref_clk, // clock
  input wire logic i_rst_n, // reset, active low
  input wire logic i_req, // request level
  input wire logic i_we, // write
  input wire logic [31:0] i_addr, // byte address
  input wire logic [31:0] i_wdata, // write data
  output var logic o_ack, // one-cycle answer
  output var logic [31:0] o_rdata // read data, valid with ack
);
  logic [31:0] mem [0:1023];
  logic [1:0] wait_cnt;
  logic slow;
  // answers alternate between prompt and two cycles late
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ack <= 1'b0;
      o_rdata <= 32'h0;
      wait_cnt <= 2'h0;
      slow <= 1'b0;
    end else begin
      o_ack <= 1'b0;
      // stale data inverts every cycle, so a late sample shows up
      o_rdata <= ~o_rdata;
      if (i_req && !o_ack) begin
        if (wait_cnt == {slow, 1'b0}) begin
          o_ack <= 1'b1;
          wait_cnt <= 2'h0;
          slow <= !slow;
          if (i_we) mem[i_addr[11:2]] <= i_wdata;
          else o_rdata <= mem[i_addr[11:2]];
        end else begin
          wait_cnt <= wait_cnt + 2'h1;
        end
      end
    end
  end
endmodule // dms_mem_model
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dms_map.vh"
module testbench;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [31:0] adr = 32'h0;
  logic [31:0] wdat = 32'h0;
  logic [15:0] preq = 16'h0;
  wire [31:0] rdat, maddr, mwdata, mrdata;
  wire ack, mreq, mwe, mack, irq;
  wire [15:0] pack;
  wire [1:0] mlay, msz;
  logic [1:0] wlay = 2'h0;
  logic [1:0] wsz = 2'h0;
  int err_count = 0;
  int num_checks = 0;
  int cyc_cnt = 0;
  int pa_cnt = 0;
  int pa_bad = 0;
  always #5 i_ref_clk = ~i_ref_clk;
  dms_channel dut (.i_ref_clk, .i_rst_n, .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .o_mem_req(mreq), .o_mem_we(mwe),
    .o_mem_addr(maddr), .o_mem_wdata(mwdata), .o_mem_layer(mlay), .o_mem_size(msz), .i_mem_ack(mack),
    .i_mem_rdata(mrdata), .i_periph_req(preq), .o_periph_ack(pack), .o_irq(irq));
  dms_mem_model mem_i (.i_ref_clk, .i_rst_n, .i_req(mreq), .i_we(mwe), .i_addr(maddr), .i_wdata(mwdata),
    .o_ack(mack), .o_rdata(mrdata));
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge i_ref_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (pack[3] === 1'b1) pa_cnt <= pa_cnt + 1;
    if ((pack & 16'hFFF7) !== 16'h0) pa_bad <= pa_bad + 1;
    // layer and width of the last write the memory took
    if (mreq === 1'b1 && mwe === 1'b1 && mack === 1'b1) begin
      wlay <= mlay;
      wsz <= msz;
    end
    if (cyc_cnt == 30000) begin
      err_count = err_count + 1;
      $display("[FAIL] %0t timeout", $time);
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge i_ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {24'h0, a};
    wdat <= d;
    @(posedge i_ref_clk);
    while (ack !== 1'b1) @(posedge i_ref_clk);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  // bounded poll of one status bit
  task automatic wait_status(input int b, input logic v);
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      wb(1'b0, `DMS_OFS_STATUS, 32'h0, q);
      n++;
    end while (q[b] !== v && n < 500);
    if (q[b] !== v) begin
      err_count++;
      $display("[FAIL] %0t status bit %0d never reached", $time, b);
    end
  endtask
  task automatic put_desc(input int b, input logic [31:0] da, input logic [31:0] nx);
    mem_i.mem[b] = 32'h00000300;
    mem_i.mem[b + 1] = da;
    mem_i.mem[b + 2] = 32'h22000001;
    mem_i.mem[b + 3] = 32'h00010000;
    mem_i.mem[b + 4] = nx;
  endtask
  task automatic t_reset;
    rd_chk(`DMS_OFS_STATUS, 32'h0);
    rd_chk(`DMS_OFS_IRQ_MASK, 32'h0);
    wr(8'h3C, 32'hFFFFFFFF);
    rd_chk(8'h3C, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_contig;
    mem_i.mem[64] = 32'hA0A00001;
    mem_i.mem[65] = 32'hA1A10002;
    wr(`DMS_OFS_GLOBAL_EN, 32'h1);
    wr(`DMS_OFS_IRQ_MASK, 32'h1);
    wr(`DMS_OFS_SADDR, 32'h100);
    wr(`DMS_OFS_DADDR, 32'h200);
    wr(`DMS_OFS_DSCR, 32'h0);
    wr(`DMS_OFS_CTRLA, 32'h22000002);
    wr(`DMS_OFS_CTRLB, 32'h80400000);
    wr(`DMS_OFS_CFG, 32'h00000203);
    preq <= 16'h0008;
    wr(`DMS_OFS_HANDLER, 32'h1);
    wait_status(`DMS_STATUS_STALL_BIT, 1'b1);
    chk({31'h0, irq}, 32'h1);
    rd_chk(`DMS_OFS_STATUS, 32'h101);
    chk(mem_i.mem[128], 32'hA0A00001);
    chk(mem_i.mem[129], 32'hA1A10002);
    rd_chk(`DMS_OFS_IRQ_STATUS, 32'h1);
    wr(`DMS_OFS_CTRLB, 32'h00400000);
    wr(`DMS_OFS_HANDLER, 32'h100);
    wait_status(`DMS_STATUS_ENA_BIT, 1'b0);
    preq <= 16'h0;
    chk(mem_i.mem[130], 32'hA0A00001);
    chk(mem_i.mem[131], 32'hA1A10002);
    rd_chk(`DMS_OFS_IRQ_STATUS, 32'h101);
    rd_chk(`DMS_OFS_IRQ_STATUS, 32'h0);
    chk(pa_cnt, 32'h4);
    chk(pa_bad, 32'h0);
    $display("test contiguous done");
  endtask
  task automatic t_linked;
    rd_chk(`DMS_OFS_STATUS, 32'h0);
    mem_i.mem[192] = 32'hDEAD0BAD;
    put_desc(256, 32'h600, 32'h420);
    put_desc(264, 32'h700, 32'h0);
    wr(`DMS_OFS_IRQ_MASK, 32'h0);
    wr(`DMS_OFS_SADDR, 32'h100);
    wr(`DMS_OFS_CTRLB, 32'h00010000);
    wr(`DMS_OFS_CFG, 32'h0);
    wr(`DMS_OFS_DSCR, 32'h400);
    wr(`DMS_OFS_HANDLER, 32'h1);
    wait_status(`DMS_STATUS_ENA_BIT, 1'b0);
    chk(mem_i.mem[384], 32'hA0A00001);
    chk(mem_i.mem[448], 32'hA0A00001);
    rd_chk(`DMS_OFS_DADDR, 32'h00000704);
    chk(mem_i.mem[258], 32'hA2000001);
    chk(mem_i.mem[266], 32'hA2000001);
    rd_chk(`DMS_OFS_IRQ_STATUS, 32'h101);
    chk({31'h0, irq}, 32'h0);
    $display("test linked done");
  endtask
  // masked auto mode, software handshake, half-word pip destination
  task automatic t_masked;
    mem_i.mem[160] = 32'h0;
    mem_i.mem[164] = 32'h0;
    rd_chk(`DMS_OFS_STATUS, 32'h0);
    preq <= 16'h0008;
    wr(`DMS_OFS_IRQ_MASK, 32'h0);
    wr(`DMS_OFS_SADDR, 32'h100);
    wr(`DMS_OFS_DADDR, 32'h280);
    wr(`DMS_OFS_DSCR, 32'h0);
    wr(`DMS_OFS_CTRLA, 32'h12000001);
    wr(`DMS_OFS_CTRLB, 32'h80401011);
    wr(`DMS_OFS_CFG, 32'h00000003);
    wr(`DMS_OFS_DEST_PIP_ENABLE, 32'h0000000E);
    wr(`DMS_OFS_HANDLER, 32'h1);
    repeat (40) @(posedge i_ref_clk);
    chk(mem_i.mem[160], 32'h0);
    wr(`DMS_OFS_SWREQ, 32'h1);
    repeat (40) @(posedge i_ref_clk);
    chk(mem_i.mem[160], 32'hA0A00001);
    chk(mem_i.mem[164], 32'h0);
    rd_chk(`DMS_OFS_STATUS, 32'h1);
    chk({30'h0, wlay}, 32'h1);
    chk({30'h0, wsz}, 32'h1);
    wr(`DMS_OFS_CTRLB, 32'h00401011);
    wr(`DMS_OFS_SWREQ, 32'h1);
    wait_status(`DMS_STATUS_ENA_BIT, 1'b0);
    preq <= 16'h0;
    chk(mem_i.mem[164], 32'hA0A00001);
    rd_chk(`DMS_OFS_DADDR, 32'h000002A0);
    rd_chk(`DMS_OFS_IRQ_STATUS, 32'h101);
    chk(pa_cnt, 32'h4);
    $display("test masked done");
  endtask
  initial begin
    repeat (10) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    t_reset();
    t_contig();
    t_linked();
    t_masked();
    summarize();
  end
endmodule // testbench
`default_nettype wire
